// File: core/swsq_consts.vh
// Constants for the stop mode wake sequencer.
`ifndef SWSQ_CONSTS_VH
`define SWSQ_CONSTS_VH
// Register byte offsets.
`define SWSQ_ADDR_CTRL 8'h00
`define SWSQ_ADDR_WAKE_EN 8'h04
`define SWSQ_ADDR_PRESCALER 8'h08
`define SWSQ_ADDR_TIMER1 8'h0C
`define SWSQ_ADDR_STATUS 8'h10
// Control register fields.
`define SWSQ_CTRL_STAB_SEL 0
`define SWSQ_CTRL_MAIN_ON 1
`define SWSQ_CTRL_SUB_ON 2
`define SWSQ_CTRL_SYS_SUB 3
`define SWSQ_CTRL_TXY_EVT_LO 4
`define SWSQ_CTRL_SIO_EXT_LO 6
`define SWSQ_CTRL_RESET 8'h02
`define SWSQ_CTRL_MASK 8'hFF
// Wake source bit positions.
`define SWSQ_WAKE_EXT_LO 0
`define SWSQ_WAKE_CNTR_LO 4
`define SWSQ_WAKE_SIO_LO 6
`define SWSQ_WAKE_TXY_LO 8
`define SWSQ_WAKE_N 10
`define SWSQ_WAKE_EN_RESET 10'h000
// Automatic stabilising load values and reset values.
`define SWSQ_PRE_AUTO 8'hFF
`define SWSQ_T1_AUTO 8'h01
`define SWSQ_PRE_RESET 8'hFF
`define SWSQ_T1_RESET 8'h01
// Timing counts in main-clock cycles.
`define SWSQ_SRC_DIV 16
`define SWSQ_RST_HOLD_CYC 20
`define SWSQ_RST_RELEASE_CYC 14
`endif

// File: core/swsq_sequencer.v
// Stop mode wake sequencer with an AHB-Lite register slave.
`timescale 1ns/100ps
// Operation
// - Stop instruction halts the CPU until stop mode is released.
// - Stop mode halts both oscillators and holds the internal clock high.
// - Ports keep direction and output state during stop mode.
// - Stop mode stops CPU, PWM, watchdog, A-D and other peripherals.
// - Timers 1 and 2 stop; X and Y run only as event counters.
// - Serial units run in stop mode only with an external clock.
// - Stop mode ends on reset pin low or enabled wake interrupt.
// - Reset during stop forces ports to input and restarts main oscillator.
// - Internal reset releases about 10.5 to 18.5 cycles after pin rises; code: 14 cycles, none if pin was low under 20 cycles.
// - Reset exit keeps RAM; CPU and control registers take reset values.
// - Wake sources: external pins, counter pins, external-clock serial, event timers.
// - Clock withheld while prescaler 12 and timer 1 count; restored at underflow.
// - With select 0, stop loads FF and 01 into prescaler and timer 1.
// - With select 1, stop leaves prescaler and timer 1 unchanged.
// - Count source feeds prescaler 12 as soon as oscillation restarts.
// - Interrupt wake keeps mode settings and restarts formerly running oscillators.
// - Main clock wake gives roughly 8000 cycles of stabilising time.
`include "swsq_consts.vh"
module swsq_sequencer #(
  parameter SRC_DIV = `SWSQ_SRC_DIV,
  parameter RST_HOLD = `SWSQ_RST_HOLD_CYC,
  parameter RST_RELEASE = `SWSQ_RST_RELEASE_CYC
)(
  // Clock and reset.
  input wire hclk,
  input wire hresetn,
  // AHB-Lite slave.
  input wire hsel,
  input wire [7:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg [31:0] hrdata,
  output reg hreadyout,
  output reg hresp,
  // CPU side.
  input wire stop_exec,
  input wire int_disable_flag,
  output reg cpu_halt,
  output reg phi_hold_high,
  output reg irq_accept,
  output reg [3:0] irq_source,
  output reg sys_reset,
  // Reset pin and wake requests.
  input wire reset_pin_n,
  input wire [`SWSQ_WAKE_N-1:0] wake_req,
  // Oscillator and peripheral controls.
  output reg main_osc_run,
  output reg sub_osc_run,
  output reg port_retain,
  output reg port_force_input,
  output reg periph_stop,
  output reg timer12_stop,
  output reg [1:0] timer_xy_run,
  output reg [1:0] sio_run
);

  ////////////////////////////////////////////////////////////////////////////
  localparam ST_RUN = 3'd0;
  localparam ST_STOP = 3'd1;
  localparam ST_STAB = 3'd2;
  localparam ST_RST_HOLD = 3'd3;
  localparam ST_RST_REL = 3'd4;

  // Picks the lowest numbered pending wake source.
  function [3:0] first_source;
    input [`SWSQ_WAKE_N-1:0] req;
    integer i;
    begin
      first_source = 4'h0;
      for (i = `SWSQ_WAKE_N - 1; i >= 0; i = i - 1)
      begin
        if (req[i])
        begin
          first_source = i[3:0];
        end
      end
    end
  endfunction

  reg [2:0] state;
  reg [7:0] ctrl;
  reg [`SWSQ_WAKE_N-1:0] wake_en;
  reg [7:0] pre_latch;
  reg [7:0] pre_cnt;
  reg [7:0] t1_latch;
  reg [7:0] t1_cnt;
  reg [7:0] div_cnt;
  reg [7:0] rst_cnt;
  reg [3:0] wake_src;
  reg rst_exit;
  reg wr_pend;
  reg [7:0] wr_addr;

  ////////////////////////////////////////////////////////////////////////////
  // Wake qualification.
  wire [`SWSQ_WAKE_N-1:0] wake_capable;
  wire [`SWSQ_WAKE_N-1:0] wake_hit;
  wire wake_any;
  wire src_tick;
  wire pre_uf;
  wire t1_uf;
  wire addr_ok;
  wire wr_do;

  assign wake_capable = {ctrl[`SWSQ_CTRL_TXY_EVT_LO+1:`SWSQ_CTRL_TXY_EVT_LO],
                         ctrl[`SWSQ_CTRL_SIO_EXT_LO+1:`SWSQ_CTRL_SIO_EXT_LO],
                         6'h3F};
  assign wake_hit = wake_req & wake_en & wake_capable;
  assign wake_any = (|wake_hit) & ~int_disable_flag;
  assign src_tick = (div_cnt == SRC_DIV[7:0] - 8'h01);
  assign pre_uf = src_tick && (pre_cnt == 8'h00);
  assign t1_uf = pre_uf && (t1_cnt == 8'h00);
  assign addr_ok = hsel & htrans[1] & hready;
  assign wr_do = wr_pend;

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer state, counters and registers.
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state <= ST_RUN;
      ctrl <= `SWSQ_CTRL_RESET;
      wake_en <= `SWSQ_WAKE_EN_RESET;
      pre_latch <= `SWSQ_PRE_RESET;
      pre_cnt <= `SWSQ_PRE_RESET;
      t1_latch <= `SWSQ_T1_RESET;
      t1_cnt <= `SWSQ_T1_RESET;
      div_cnt <= 8'h00;
      rst_cnt <= 8'h00;
      wake_src <= 4'h0;
      rst_exit <= 1'b0;
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
    end
    else
    begin
      wr_pend <= addr_ok & hwrite;
      if (addr_ok)
      begin
        wr_addr <= haddr;
      end
      case (state)
        ST_RUN:
        begin
          if (!reset_pin_n)
          begin
            state <= ST_RST_HOLD;
            rst_cnt <= 8'h00;
          end
          else if (stop_exec)
          begin
            state <= ST_STOP;
            if (!ctrl[`SWSQ_CTRL_STAB_SEL])
            begin
              pre_latch <= `SWSQ_PRE_AUTO;
              pre_cnt <= `SWSQ_PRE_AUTO;
              t1_latch <= `SWSQ_T1_AUTO;
              t1_cnt <= `SWSQ_T1_AUTO;
            end
            // A set select bit leaves the software values in place.
          end
          else if (wr_do)
          begin
            case (wr_addr)
              `SWSQ_ADDR_CTRL: ctrl <= hwdata[7:0];
              `SWSQ_ADDR_WAKE_EN: wake_en <= hwdata[`SWSQ_WAKE_N-1:0];
              `SWSQ_ADDR_PRESCALER:
              begin
                pre_latch <= hwdata[7:0];
                pre_cnt <= hwdata[7:0];
              end
              `SWSQ_ADDR_TIMER1:
              begin
                t1_latch <= hwdata[7:0];
                t1_cnt <= hwdata[7:0];
              end
              default: ctrl <= ctrl;
            endcase
          end
        end
        ST_STOP:
        begin
          div_cnt <= 8'h00;
          if (!reset_pin_n)
          begin
            state <= ST_RST_HOLD;
            rst_cnt <= 8'h00;
          end
          else if (wake_any)
          begin
            state <= ST_STAB;
            wake_src <= first_source(wake_hit);
          end
        end
        ST_STAB:
        begin
          // The count source runs from the first cycle of oscillation.
          div_cnt <= src_tick ? 8'h00 : div_cnt + 8'h01;
          if (!reset_pin_n)
          begin
            state <= ST_RST_HOLD;
            rst_cnt <= 8'h00;
          end
          else if (src_tick)
          begin
            pre_cnt <= pre_uf ? pre_latch : pre_cnt - 8'h01;
            if (pre_uf)
            begin
              t1_cnt <= t1_uf ? t1_latch : t1_cnt - 8'h01;
            end
            if (t1_uf)
            begin
              state <= ST_RUN;
            end
          end
        end
        ST_RST_HOLD:
        begin
          if (reset_pin_n)
          begin
            state <= (rst_cnt >= RST_HOLD[7:0]) ? ST_RST_REL : ST_RUN;
            rst_cnt <= 8'h00;
          end
          else if (rst_cnt < RST_HOLD[7:0])
          begin
            rst_cnt <= rst_cnt + 8'h01;
          end
          ctrl <= `SWSQ_CTRL_RESET;
          wake_en <= `SWSQ_WAKE_EN_RESET;
          pre_latch <= `SWSQ_PRE_RESET;
          pre_cnt <= `SWSQ_PRE_RESET;
          t1_latch <= `SWSQ_T1_RESET;
          t1_cnt <= `SWSQ_T1_RESET;
        end
        ST_RST_REL:
        begin
          rst_cnt <= rst_cnt + 8'h01;
          if (!reset_pin_n)
          begin
            state <= ST_RST_HOLD;
            rst_cnt <= 8'h00;
          end
          else if (rst_cnt == RST_RELEASE[7:0] - 8'h01)
          begin
            state <= ST_RUN;
          end
        end
        default: state <= ST_RUN;
      endcase
      // The exit flag stays set until the next stop instruction is taken.
      rst_exit <= (state == ST_RST_REL) || (rst_exit && !(state == ST_RUN && stop_exec));
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registered outputs.
  wire in_stop;
  wire in_stab;
  wire in_rst;

  assign in_stop = (state == ST_STOP);
  assign in_stab = (state == ST_STAB);
  assign in_rst = (state == ST_RST_HOLD) || (state == ST_RST_REL);

  // The clock is released in the same cycle as the waking request is accepted.
  wire stab_done;
  wire held;

  assign stab_done = in_stab & t1_uf & reset_pin_n;
  assign held = in_stop | (in_stab & ~stab_done);

  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      cpu_halt <= 1'b0;
      phi_hold_high <= 1'b0;
      irq_accept <= 1'b0;
      irq_source <= 4'h0;
      sys_reset <= 1'b1;
      main_osc_run <= 1'b1;
      sub_osc_run <= 1'b0;
      port_retain <= 1'b0;
      port_force_input <= 1'b1;
      periph_stop <= 1'b0;
      timer12_stop <= 1'b0;
      timer_xy_run <= 2'h3;
      sio_run <= 2'h3;
    end
    else
    begin
      cpu_halt <= held | in_rst;
      phi_hold_high <= held;
      irq_accept <= stab_done;
      irq_source <= stab_done ? wake_src : irq_source;
      sys_reset <= in_rst;
      main_osc_run <= in_rst | (~in_stop & ctrl[`SWSQ_CTRL_MAIN_ON]);
      sub_osc_run <= ~in_stop & ~in_rst & ctrl[`SWSQ_CTRL_SUB_ON];
      port_retain <= held;
      port_force_input <= in_rst;
      periph_stop <= held;
      timer12_stop <= in_stop;
      timer_xy_run <= held ?
        ctrl[`SWSQ_CTRL_TXY_EVT_LO+1:`SWSQ_CTRL_TXY_EVT_LO] : 2'h3;
      sio_run <= held ?
        ctrl[`SWSQ_CTRL_SIO_EXT_LO+1:`SWSQ_CTRL_SIO_EXT_LO] : 2'h3;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus read data, latched in the address phase.
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hrdata <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
    else
    begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      if (addr_ok && !hwrite)
      begin
        case (haddr)
          `SWSQ_ADDR_CTRL: hrdata <= {24'h000000, ctrl};
          `SWSQ_ADDR_WAKE_EN: hrdata <= {22'h000000, wake_en};
          `SWSQ_ADDR_PRESCALER: hrdata <= {16'h0000, pre_latch, pre_cnt};
          `SWSQ_ADDR_TIMER1: hrdata <= {16'h0000, t1_latch, t1_cnt};
          `SWSQ_ADDR_STATUS:
            hrdata <= {20'h00000, wake_src, 3'h0, rst_exit, 1'b0, state};
          default: hrdata <= 32'h00000000;
        endcase
      end
    end
  end

endmodule // swsq_sequencer

// File: verif/swsq_checker.sv
// Assertion checker for the stop mode wake sequencer.
`timescale 1ns/100ps
module swsq_checker #(
  parameter RST_RELEASE = 14
)(
  // Clock and reset.
  input wire hclk,
  input wire hresetn,
  // Observed ports.
  input wire stop_exec,
  input wire reset_pin_n,
  input wire cpu_halt,
  input wire phi_hold_high,
  input wire irq_accept,
  input wire sys_reset,
  input wire port_retain,
  input wire port_force_input,
  input wire periph_stop,
  input wire timer12_stop,
  input wire main_osc_run
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic rel_on;
  logic [7:0] rel_cnt;
  ////////////////////////////////////////////////////////////////////////////////
  // Counts the cycles of internal reset after the pin rises.
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      rel_on <= 1'b0;
    else if (!reset_pin_n)
      rel_on <= 1'b1;
    else if (!sys_reset)
      rel_on <= 1'b0;
  end
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      rel_cnt <= 8'h00;
    else if (!reset_pin_n)
      rel_cnt <= 8'h00;
    else if (rel_on && sys_reset)
      rel_cnt <= rel_cnt + 8'h01;
  end
  ////////////////////////////////////////////////////////////////////////////////
  chk_stop_entry:
  assert property (stop_exec && reset_pin_n && !cpu_halt && !sys_reset
    |-> ##[1:2] (cpu_halt && phi_hold_high && !main_osc_run)) else $error("stop not entered");
  chk_halt_clock:
  assert property (cpu_halt && !sys_reset && !$past(sys_reset) |-> phi_hold_high)
    else $error("clock not held while halted");
  chk_irq_release:
  assert property (irq_accept |-> !cpu_halt && !phi_hold_high && $past(phi_hold_high))
    else $error("wake accept without clock release");
  chk_irq_pulse:
  assert property (irq_accept |=> !irq_accept) else $error("accept pulse too long");
  chk_stop_hold:
  assert property (port_retain |-> periph_stop && (timer12_stop || $past(port_retain)))
    else $error("units run in stop");
  chk_pin_reset:
  assert property (!reset_pin_n |-> ##2 (sys_reset && port_force_input && main_osc_run
    && !port_retain))
    else $error("pin reset not applied");
  chk_rst_late:
  assert property (rel_on && sys_reset && reset_pin_n |-> rel_cnt <= RST_RELEASE + 3)
    else $error("internal reset held too long");
  chk_rst_early:
  assert property (rel_on && $fell(sys_reset) |-> rel_cnt >= RST_RELEASE - 3)
    else $error("internal reset released too early");
  chk_wake_min:
  assert property ($rose(phi_hold_high) |-> phi_hold_high[*3]) else $error("clock held too briefly");
  cover property (irq_accept);
  cover property (rel_on && $fell(sys_reset));
  cover property (stop_exec && !cpu_halt);
endmodule // swsq_checker
bind swsq_sequencer swsq_checker #(.RST_RELEASE(RST_RELEASE)) u_chk (.hclk(hclk),
  .hresetn(hresetn), .stop_exec(stop_exec), .reset_pin_n(reset_pin_n), .cpu_halt(cpu_halt),
  .phi_hold_high(phi_hold_high), .irq_accept(irq_accept), .sys_reset(sys_reset),
  .port_retain(port_retain), .port_force_input(port_force_input), .periph_stop(periph_stop),
  .timer12_stop(timer12_stop), .main_osc_run(main_osc_run));

// File: verif/swsq_partner.sv
// Model of the CPU core, reset pin and wake sources.
`timescale 1ns/100ps
module swsq_partner (
  // Clock and acceptance.
  input wire hclk,
  input wire irq_accept,
  // Driven lines.
  output logic stop_exec = 1'b0,
  output logic int_disable_flag = 1'b0,
  output logic reset_pin_n = 1'b1,
  output logic [9:0] wake_req = 10'h000
);
  ////////////////////////////////////////////////////////////////////////////////
  task stop_pulse;
    @(posedge hclk);
    stop_exec <= 1'b1;
    @(posedge hclk);
    stop_exec <= 1'b0;
  endtask
  task req(input logic [9:0] m);
    @(posedge hclk);
    wake_req <= m;
  endtask
  task flag(input logic v);
    @(posedge hclk);
    int_disable_flag <= v;
  endtask
  task pin(input logic v);
    @(posedge hclk);
    reset_pin_n <= v;
  endtask
  // All pending requests are cleared as the core enters its service routine.
  always @(posedge hclk)
  begin
    if (irq_accept)
      wake_req <= 10'h000;
  end
endmodule // swsq_partner

// File: verif/testbench.sv
// Self-checking testbench for the stop mode wake sequencer.
`timescale 1ns/100ps
`include "swsq_consts.vh"
module testbench;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0, hwrite = 1'b0;
  logic [7:0] haddr = 8'h00;
  logic [2:0] hsize = 3'b000;
  logic [1:0] htrans = 2'b00;
  logic [31:0] hwdata = 32'h0, hrdata;
  logic hreadyout, hresp, cpu_halt, phi_hold_high, irq_accept, sys_reset, main_osc_run;
  logic sub_osc_run, port_retain, port_force_input, periph_stop, timer12_stop;
  logic stop_exec, int_disable_flag, reset_pin_n;
  logic [3:0] irq_source;
  logic [1:0] timer_xy_run, sio_run;
  logic [9:0] wake_req;
  int bad_count = 0;
  int tests_run = 0;
  swsq_sequencer #(.SRC_DIV(2)) DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .stop_exec(stop_exec), .int_disable_flag(int_disable_flag), .cpu_halt(cpu_halt),
    .phi_hold_high(phi_hold_high), .irq_accept(irq_accept), .irq_source(irq_source),
    .sys_reset(sys_reset), .reset_pin_n(reset_pin_n), .wake_req(wake_req),
    .main_osc_run(main_osc_run), .sub_osc_run(sub_osc_run), .port_retain(port_retain),
    .port_force_input(port_force_input), .periph_stop(periph_stop),
    .timer12_stop(timer12_stop), .timer_xy_run(timer_xy_run), .sio_run(sio_run));
  swsq_partner u_cpu (.hclk(hclk), .irq_accept(irq_accept), .stop_exec(stop_exec),
    .int_disable_flag(int_disable_flag), .reset_pin_n(reset_pin_n), .wake_req(wake_req));
  always #5 hclk = ~hclk;
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      bad_count++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] r);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    hsize <= 3'b010;
    htrans <= 2'b10;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    xfer(1'b1, a, d, r);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] r;
    xfer(1'b0, a, 32'h0, r);
    chk(r & m, e);
  endtask
  task automatic wait_irq(output int n);
    n = 0;
    while (irq_accept !== 1'b1 && n < 3000)
    begin
      @(posedge hclk);
      n++;
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_regs;
    rdc(`SWSQ_ADDR_CTRL, 32'hFFFFFFFF, 32'h02);
    rdc(`SWSQ_ADDR_PRESCALER, 32'hFFFFFFFF, 32'hFFFF);
    rdc(`SWSQ_ADDR_TIMER1, 32'hFFFFFFFF, 32'h0101);
    rdc(`SWSQ_ADDR_STATUS, 32'hFFFFFFFF, 32'h0);
    wr(`SWSQ_ADDR_WAKE_EN, 32'hFFFFFFFF);
    rdc(`SWSQ_ADDR_WAKE_EN, 32'hFFFFFFFF, 32'h3FF);
    wr(8'h20, 32'h5A);
    rdc(8'h20, 32'hFFFFFFFF, 32'h0);
  endtask
  task automatic t_auto;
    int n;
    wr(`SWSQ_ADDR_CTRL, 32'h16);
    wr(`SWSQ_ADDR_PRESCALER, 32'h05);
    wr(`SWSQ_ADDR_TIMER1, 32'h03);
    wr(`SWSQ_ADDR_WAKE_EN, 32'h001);
    u_cpu.stop_pulse;
    repeat (3) @(posedge hclk);
    chk({cpu_halt, phi_hold_high, main_osc_run, sub_osc_run}, 4'b1100);
    chk({port_retain, periph_stop, timer12_stop, timer_xy_run, sio_run}, 7'h74);
    u_cpu.req(10'h001);
    wait_irq(n);
    chk(n >= 1024 && n <= 1032, 1);
    chk({irq_source, cpu_halt, main_osc_run, sub_osc_run}, 7'h03);
    rdc(`SWSQ_ADDR_PRESCALER, 32'hFF00, 32'hFF00);
    rdc(`SWSQ_ADDR_TIMER1, 32'hFF00, 32'h0100);
    wr(`SWSQ_ADDR_PRESCALER, 32'h05);
    rdc(`SWSQ_ADDR_PRESCALER, 32'hFFFF, 32'h0505);
    rdc(`SWSQ_ADDR_CTRL, 32'hFF, 32'h16);
  endtask
  task automatic t_manual;
    int n;
    logic [9:0] m[3] = '{10'h004, 10'h100, 10'h080};
    wr(`SWSQ_ADDR_CTRL, 32'hC3);
    wr(`SWSQ_ADDR_PRESCALER, 32'h01);
    wr(`SWSQ_ADDR_TIMER1, 32'h00);
    wr(`SWSQ_ADDR_WAKE_EN, 32'h180);
    u_cpu.stop_pulse;
    for (int i = 0; i < 3; i++)
    begin
      u_cpu.flag(i == 2);
      u_cpu.req(m[i]);
      repeat (10) @(posedge hclk);
      chk({cpu_halt, sio_run, timer_xy_run}, 5'b11100);
    end
    u_cpu.flag(1'b0);
    wait_irq(n);
    chk(n >= 4 && n <= 12, 1);
    chk(irq_source, 4'h7);
    rdc(`SWSQ_ADDR_PRESCALER, 32'hFF00, 32'h0100);
  endtask
  task automatic t_reset;
    int n;
    wr(`SWSQ_ADDR_CTRL, 32'h16);
    u_cpu.stop_pulse;
    repeat (3) @(posedge hclk);
    u_cpu.pin(1'b0);
    repeat (3) @(posedge hclk);
    chk({sys_reset, port_force_input, port_retain, main_osc_run}, 4'b1101);
    repeat (28) @(posedge hclk);
    u_cpu.pin(1'b1);
    n = 0;
    while (sys_reset !== 1'b0 && n < 100)
    begin
      @(posedge hclk);
      n++;
    end
    chk(n >= 11 && n <= 18, 1);
    rdc(`SWSQ_ADDR_CTRL, 32'hFF, 32'h02);
    rdc(`SWSQ_ADDR_STATUS, 32'h10, 32'h10);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task give_verdict;
    $display("Checks %0d, mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial
  begin
    #200000;
    bad_count++;
    give_verdict;
  end
  initial
  begin
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    t_regs;
    t_auto;
    t_manual;
    t_reset;
    give_verdict;
  end
endmodule // testbench
